// >>> verilog/pph_pkg.sv
// shared constants for the profile position handshake
package pph_pkg;

  // ------------------------------------------------------------
  // command word (link object 0x6040) and status word (0x6041)
  // ------------------------------------------------------------
  localparam logic [15:0] CMD_WORD_INDEX  = 16'h6040;
  localparam logic [15:0] STAT_WORD_INDEX = 16'h6041;
  localparam int CMD_STROBE   = 4;   // new set-point
  localparam int CMD_IMMED    = 5;   // change set immediately
  localparam int CMD_RELSEL   = 6;   // absolute / relative select
  localparam int CMD_HALT     = 8;
  localparam int CMD_COSP     = 9;   // change on set-point, no effect
  localparam int STAT_WARN    = 7;   // command warning
  localparam int STAT_REACHED = 10;
  localparam int STAT_ACK     = 12;
  localparam int STAT_FERR    = 13;
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  // ------------------------------------------------------------
  // halt options, homing, following error window
  // ------------------------------------------------------------
  localparam logic [2:0]  HALT_QUICK       = 3'h2;     // stop at once
  localparam logic [31:0] HALT_DECEL_STEP  = 32'h0000_0010;
  localparam logic [7:0]  HOME_METHOD_OK   = 8'h23;     // only supported method
  localparam logic [31:0] HOME_POSITION    = 32'h0000_0000;
  localparam logic [31:0] HOME_SPEED       = 32'h0000_0008;
  localparam logic [31:0] FERR_WIN_ALWAYS  = 32'h0000_0000;
  localparam logic [31:0] FERR_WIN_OFF     = 32'hffff_ffff;
  localparam logic [31:0] FERR_WIN_CAP     = 32'h0800_0000;
  localparam logic [31:0] FERR_WIN_RESET   = 32'h0001_86a0;

  // ------------------------------------------------------------
  // host timing: target held this many link cycles plus one before strobe
  // ------------------------------------------------------------
  localparam logic [1:0] HOLD_CYCLES = 2'h2;

  // ------------------------------------------------------------
  // host apb register map
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TARGET = 8'h04;
  localparam logic [7:0] REG_VEL    = 8'h08;
  localparam logic [7:0] REG_OPTS   = 8'h0c;
  localparam logic [7:0] REG_WINDOW = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_GO     = 0;   // write 1 to issue a set-point
  localparam int CTRL_HALT   = 1;
  localparam int CTRL_HOMING = 2;
  localparam int OPTS_METHOD = 0;   // bits 7:0
  localparam int OPTS_HALTOP = 8;   // bits 10:8
  localparam int STAT_BUSY   = 16;

  typedef enum logic [1:0] {
    HS_IDLE   = 2'b00,
    HS_HOLD   = 2'b01,
    HS_STROBE = 2'b10,
    HS_DROP   = 2'b11
  } pph_host_state_t;

endpackage : pph_pkg

// >>> verilog/pph_link_if.sv
// cyclic link between host motion controller and drive
`timescale 1ns/1ps
interface pph_link_if;
  logic [15:0] cmdWord;      // host -> drive
  logic [31:0] targetPos;
  logic [31:0] profileVel;
  logic [2:0]  haltOption;
  logic        homingMode;
  logic [7:0]  homingMethod;
  logic [31:0] ferrWindow;
  logic [15:0] statusWord;   // drive -> host

  modport drive (input cmdWord, targetPos, profileVel, haltOption, homingMode,
                 homingMethod, ferrWindow, output statusWord);
  modport host  (output cmdWord, targetPos, profileVel, haltOption, homingMode,
                 homingMethod, ferrWindow, input statusWord);
endinterface : pph_link_if

// >>> verilog/pph_drive_end.sv
// drive end: set-point handshake, path generation, status word
//
// Chosen here: no register port; the drive end is set only over the link.
`timescale 1ns/1ps

module pph_drive_end (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // link to host
  pph_link_if.drive        link,
  // servo side
  input  wire logic [31:0] actualPos,
  output logic      [31:0] demandPos,
  output logic      [31:0] demandSpeed,
  output logic             moving
);
  import pph_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // magnitude of a signed 32-bit difference, one bit wider
  function automatic logic [32:0] absDiff(input logic [31:0] a, input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    absDiff = d[32] ? 33'(-d) : 33'(d);
  endfunction : absDiff

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic        strobeQ;
  logic        strobeRise;
  logic        badCmd;
  logic        accept;
  logic        halt;
  logic [31:0] tgtPos;
  logic [31:0] tgtVel;
  logic        active;
  logic        ack;
  logic        warn;
  logic        reached;
  logic        ferr;
  logic [32:0] remain;
  logic [31:0] step;
  logic [32:0] lagDist;
  logic [31:0] winEff;

  // link runs on core_clk, so no synchroniser is needed
  assign strobeRise = link.cmdWord[CMD_STROBE] & ~strobeQ;
  // the change-on-set-point bit is never decoded
  assign badCmd = ~link.cmdWord[CMD_IMMED]
                | link.cmdWord[CMD_RELSEL]
                | (link.homingMode & (link.homingMethod != HOME_METHOD_OK));
  assign accept = strobeRise & ~badCmd;
  assign halt   = link.cmdWord[CMD_HALT];

  // edge detector history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobeQ <= 1'b0;
    end else begin
      strobeQ <= link.cmdWord[CMD_STROBE];
    end
  end

  // ------------------------------------------------------------
  // set-point capture
  // ------------------------------------------------------------
  // a later accepted edge simply overwrites the running set-point
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tgtPos <= 32'h0000_0000;
      tgtVel <= 32'h0000_0000;
    end else if (accept) begin
      tgtPos <= link.homingMode ? HOME_POSITION : link.targetPos;
      tgtVel <= link.homingMode ? HOME_SPEED : link.profileVel;
    end
  end

  // ------------------------------------------------------------
  // speed: cruise at profile velocity, ramp or cut on halt
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      demandSpeed <= 32'h0000_0000;
    end else if (halt) begin
      if (link.haltOption == HALT_QUICK) begin
        demandSpeed <= 32'h0000_0000;
      end else if (demandSpeed > HALT_DECEL_STEP) begin
        demandSpeed <= demandSpeed - HALT_DECEL_STEP;
      end else begin
        demandSpeed <= 32'h0000_0000;
      end
    end else if (accept) begin
      demandSpeed <= link.homingMode ? HOME_SPEED : link.profileVel;
    end else if (active) begin
      demandSpeed <= tgtVel;
    end else begin
      demandSpeed <= 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // position path: never overshoots the target
  // ------------------------------------------------------------
  assign remain = absDiff(tgtPos, demandPos);
  assign step   = (remain < {1'b0, demandSpeed}) ? remain[31:0] : demandSpeed;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      demandPos <= 32'h0000_0000;
    end else if (active) begin
      if ($signed(tgtPos) > $signed(demandPos)) begin
        demandPos <= demandPos + step;
      end else begin
        demandPos <= demandPos - step;
      end
    end
  end

  // move is live from acceptance until the path lands on target
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active <= 1'b0;
    end else if (accept) begin
      active <= 1'b1;
    end else if (remain == 33'h0_0000_0000) begin
      active <= 1'b0;
    end
  end

  assign moving = active & (demandSpeed != 32'h0000_0000);

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // acknowledge: set wins over the clear when both land together
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else if (accept) begin
      ack <= 1'b1;
    end else if (!link.cmdWord[CMD_STROBE]) begin
      ack <= 1'b0;
    end
  end

  // command warning holds until a good set-point is taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      warn <= 1'b0;
    end else if (strobeRise && badCmd) begin
      warn <= 1'b1;
    end else if (accept) begin
      warn <= 1'b0;
    end
  end

  // target reached meaning depends on the halt bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reached <= 1'b0;
    end else if (halt) begin
      reached <= (demandSpeed == 32'h0000_0000) && !accept;
    end else begin
      reached <= !active && !accept;
    end
  end

  // following error against the servo's actual position
  assign lagDist = absDiff(demandPos, actualPos);
  assign winEff  = (link.ferrWindow > FERR_WIN_CAP) ? FERR_WIN_CAP : link.ferrWindow;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ferr <= 1'b0;
    end else if (link.ferrWindow == FERR_WIN_OFF) begin
      ferr <= 1'b0;
    end else if (link.ferrWindow == FERR_WIN_ALWAYS) begin
      ferr <= 1'b1;
    end else begin
      ferr <= lagDist > {1'b0, winEff};
    end
  end

  // ------------------------------------------------------------
  // status word assembly
  // ------------------------------------------------------------
  always_comb begin
    link.statusWord               = STAT_RESET;
    link.statusWord[STAT_WARN]    = warn;
    link.statusWord[STAT_REACHED] = reached;
    link.statusWord[STAT_ACK]     = ack;
    link.statusWord[STAT_FERR]    = ferr;
  end

endmodule : pph_drive_end

// >>> verilog/pph_host_end.sv
// host end: apb registers drive the set-point handshake
`timescale 1ns/1ps
module pph_host_end (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link to drive
  pph_link_if.host         link
);
  import pph_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic            wrEn;
  logic            goReq;
  logic            haltReg;
  logic            homingReg;
  logic [31:0]     targetReg;
  logic [31:0]     velReg;
  logic [10:0]     optsReg;
  logic [31:0]     windowReg;
  logic [1:0]      holdCnt;
  logic            strobe;
  pph_host_state_t state;
  pph_host_state_t next_state;

  assign wrEn    = psel & penable & pwrite;
  assign pready  = 1'b1;  // zero wait states
  assign pslverr = psel & penable & !(paddr == REG_CTRL || paddr == REG_TARGET ||
                   paddr == REG_VEL || paddr == REG_OPTS || paddr == REG_WINDOW ||
                   (paddr == REG_STATUS && !pwrite));

  // register writes; go is a pulse, dropped while busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      goReq     <= 1'b0;
      haltReg   <= 1'b0;
      homingReg <= 1'b0;
      targetReg <= 32'h0000_0000;
      velReg    <= 32'h0000_0000;
      optsReg   <= 11'h000;
      windowReg <= FERR_WIN_RESET;
    end else begin
      goReq <= 1'b0;
      if (wrEn && paddr == REG_CTRL) begin
        goReq     <= pwdata[CTRL_GO] & (state == HS_IDLE);
        haltReg   <= pwdata[CTRL_HALT];
        homingReg <= pwdata[CTRL_HOMING];
      end else if (wrEn && paddr == REG_TARGET) begin
        targetReg <= pwdata;
      end else if (wrEn && paddr == REG_VEL) begin
        velReg <= pwdata;
      end else if (wrEn && paddr == REG_OPTS) begin
        optsReg <= pwdata[10:0];
      end else if (wrEn && paddr == REG_WINDOW) begin
        windowReg <= pwdata;
      end
    end
  end

  // read mux, registered so data stands while psel holds
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == REG_CTRL) begin
        prdata <= {29'h0, homingReg, haltReg, 1'b0};
      end else if (paddr == REG_TARGET) begin
        prdata <= targetReg;
      end else if (paddr == REG_VEL) begin
        prdata <= velReg;
      end else if (paddr == REG_OPTS) begin
        prdata <= {21'h0, optsReg};
      end else if (paddr == REG_WINDOW) begin
        prdata <= windowReg;
      end else if (paddr == REG_STATUS) begin
        prdata <= {15'h0, state != HS_IDLE, link.statusWord};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // handshake sequencer
  // ------------------------------------------------------------
  // values go out first and stand still before the strobe rises
  always_comb begin
    next_state = state;
    case (state)
      HS_IDLE:   if (goReq) next_state = HS_HOLD;
      HS_HOLD:   if (holdCnt == HOLD_CYCLES) next_state = HS_STROBE;
      HS_STROBE: if (link.statusWord[STAT_ACK] || link.statusWord[STAT_WARN]) next_state = HS_DROP;
      HS_DROP:   if (!link.statusWord[STAT_ACK]) next_state = HS_IDLE;
      default:   next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= HS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // hold counter for the three-cycle settle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt <= 2'h0;
    end else if (state == HS_HOLD) begin
      holdCnt <= holdCnt + 2'h1;
    end else begin
      holdCnt <= 2'h0;
    end
  end

  // link values latched on go so a later write cannot disturb a move
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.targetPos    <= 32'h0000_0000;
      link.profileVel   <= 32'h0000_0000;
      link.homingMode   <= 1'b0;
      link.homingMethod <= 8'h00;
    end else if (goReq) begin
      link.targetPos    <= targetReg;
      link.profileVel   <= velReg;
      link.homingMode   <= homingReg;
      link.homingMethod <= optsReg[OPTS_METHOD +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe <= 1'b0;
    end else begin
      strobe <= (next_state == HS_STROBE);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.haltOption <= 3'h0;
      link.ferrWindow <= FERR_WIN_RESET;
    end else begin
      link.haltOption <= optsReg[OPTS_HALTOP +: 3];
      link.ferrWindow <= windowReg;
    end
  end

  // command word: immediate forced high, relative forced low
  always_comb begin
    link.cmdWord             = CMD_RESET;
    link.cmdWord[CMD_STROBE] = strobe;
    link.cmdWord[CMD_IMMED]  = 1'b1;
    link.cmdWord[CMD_RELSEL] = 1'b0;
    link.cmdWord[CMD_HALT]   = haltReg;
  end

endmodule : pph_host_end

// >>> verification/pph_link_sva.sv
// assertion checker for the link between host end and drive end
`timescale 1ns/1ps
module pph_link_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // link signals
  input wire logic [15:0] cmdWord,
  input wire logic [31:0] targetPos,
  input wire logic [31:0] profileVel,
  input wire logic [2:0]  haltOption,
  input wire logic        homingMode,
  input wire logic [7:0]  homingMethod,
  input wire logic [31:0] ferrWindow,
  input wire logic [15:0] statusWord
);
  import pph_pkg::*;
  logic accept;

  // legal mode bits, and a supported method when homing
  assign accept = cmdWord[CMD_IMMED] & ~cmdWord[CMD_RELSEL] & (~homingMode | (homingMethod == HOME_METHOD_OK));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // set-point handshake
  // ------------------------------------------------------------
  property p_ack_on_accept;
    $rose(cmdWord[CMD_STROBE]) && accept |=> statusWord[STAT_ACK] && !statusWord[STAT_WARN];
  endproperty
  a_ack_on_accept: assert property (p_ack_on_accept) else $error("ack missing after strobe");
  property p_ack_cause;
    $rose(statusWord[STAT_ACK]) |-> $past(cmdWord[CMD_STROBE]) && !$past(cmdWord[CMD_STROBE], 2);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe edge");
  property p_ack_release;
    !cmdWord[CMD_STROBE] [*3] |-> !statusWord[STAT_ACK];
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack stuck after strobe low");
  property p_immed_held;
    cmdWord[CMD_IMMED];
  endproperty
  a_immed_held: assert property (p_immed_held) else $error("immediate bit low");
  property p_abs_held;
    !cmdWord[CMD_RELSEL];
  endproperty
  a_abs_held: assert property (p_abs_held) else $error("relative select high");
  // values must have settled two cycles before the strobe rises
  property p_values_held;
    $rose(cmdWord[CMD_STROBE]) |-> $stable(targetPos) && $stable(profileVel) && targetPos == $past(targetPos, 2)
      && profileVel == $past(profileVel, 2);
  endproperty
  a_values_held: assert property (p_values_held) else $error("target moved before strobe");

  // ------------------------------------------------------------
  // halt and following error
  // ------------------------------------------------------------
  property p_quick_stop;
    $rose(cmdWord[CMD_HALT]) && haltOption == HALT_QUICK |-> ##[1:4] statusWord[STAT_REACHED];
  endproperty
  a_quick_stop: assert property (p_quick_stop) else $error("quick halt not at rest");
  property p_ferr_always;
    ferrWindow == FERR_WIN_ALWAYS [*3] |-> statusWord[STAT_FERR];
  endproperty
  a_ferr_always: assert property (p_ferr_always) else $error("zero window without error");
  property p_ferr_off;
    ferrWindow == FERR_WIN_OFF [*3] |-> !statusWord[STAT_FERR];
  endproperty
  a_ferr_off: assert property (p_ferr_off) else $error("error with detection off");

  c_accept: cover property ($rose(cmdWord[CMD_STROBE]) && accept);
  c_quick: cover property ($rose(cmdWord[CMD_HALT]) && haltOption == HALT_QUICK);
  c_ferr: cover property ($rose(statusWord[STAT_FERR]));
endmodule : pph_link_sva

// >>> verification/profile_position_handshake_tb.sv
// testbench: host end and drive end joined over the link, plus a faulty host on a second link
`timescale 1ns/1ps
module profile_position_handshake_tb;
  import pph_pkg::*;
  logic        core_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] actualPos;
  logic [31:0] demandPos;
  logic [31:0] demandSpeed;
  logic        moving;
  logic [31:0] posOfs;
  logic [31:0] demandPos2;
  logic [31:0] actualPos2;
  int          errors;
  int          numChecks;
  int          cycles;

  pph_link_if link ();
  pph_link_if link2 ();
  pph_host_end i_pph_host_end (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  pph_drive_end i_pph_drive_end (.core_clk(core_clk), .arst_n(arst_n), .link(link), .actualPos(actualPos),
    .demandPos(demandPos), .demandSpeed(demandSpeed), .moving(moving));
  // second drive faces a host that breaks the mode-bit rules
  pph_drive_end i_pph_drive_end_f (.core_clk(core_clk), .arst_n(arst_n), .link(link2), .actualPos(actualPos2),
    .demandPos(demandPos2), .demandSpeed(), .moving());
  pph_link_sva i_pph_link_sva (.core_clk(core_clk), .arst_n(arst_n), .cmdWord(link.cmdWord),
    .targetPos(link.targetPos), .profileVel(link.profileVel), .haltOption(link.haltOption),
    .homingMode(link.homingMode), .homingMethod(link.homingMethod), .ferrWindow(link.ferrWindow),
    .statusWord(link.statusWord));

  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  // servo follows demand with an adjustable lag to provoke following errors
  always_ff @(posedge core_clk) actualPos <= demandPos + posOfs;
  assign actualPos2 = demandPos2;
  // hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, d, rd, e);
  endtask : wr
  task automatic rdst(output logic [31:0] rd);
    logic e;
    apb(1'b0, REG_STATUS, 32'h0, rd, e);
  endtask : rdst
  // poll until the handshake is over, and optionally the motion too
  task automatic wait_idle(input logic motion);
    logic [31:0] rd;
    rd = 32'h0001_0000;
    while (rd[STAT_BUSY] !== 1'b0 || (motion && moving !== 1'b0)) rdst(rd);
  endtask : wait_idle
  task automatic final_report();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic        e;
    apb(1'b0, REG_WINDOW, 32'h0, rd, e);
    check("window reset", FERR_WIN_RESET, rd);
    check("cmd word reset", 32'h0020, 32'(link.cmdWord));
    apb(1'b0, 8'h18, 32'h0, rd, e);
    check("unmapped err", 32'h1, 32'(e));
    apb(1'b1, REG_STATUS, 32'hffff_ffff, rd, e);
    check("status write err", 32'h1, 32'(e));
    rdst(rd);
    check("ack at reset", 32'h0, 32'(rd[STAT_ACK]));
  endtask : t_reset
  task automatic t_move();
    logic [31:0] rd;
    wr(REG_TARGET, 32'h40);
    wr(REG_VEL, 32'h8);
    repeat (5) @(posedge core_clk);
    check("still before strobe", 32'h0, demandPos);
    wr(REG_CTRL, 32'h1);
    wait_idle(1'b1);
    rdst(rd);
    check("position", 32'h40, demandPos);
    check("reached", 32'h1, 32'(rd[STAT_REACHED]));
    check("ack dropped", 32'h0, 32'(rd[STAT_ACK]));
    wr(REG_TARGET, 32'h200);
    wr(REG_VEL, 32'h2);
    wr(REG_CTRL, 32'h1);
    wait_idle(1'b0);
    rdst(rd);
    check("moving", 32'h1, 32'(moving));
    check("reached in move", 32'h0, 32'(rd[STAT_REACHED]));
    check("step", 32'h2, demandSpeed);
    wr(REG_TARGET, 32'h20);
    wr(REG_VEL, 32'h4);
    wr(REG_CTRL, 32'h1);
    wait_idle(1'b1);
    check("retarget", 32'h20, demandPos);
  endtask : t_move
  // ramp option first, then quick stop; the ramp must take several cycles
  task automatic t_halt();
    int n;
    for (int opt = 0; opt < 3; opt += 2) begin
      wr(REG_OPTS, 32'(opt) << OPTS_HALTOP);
      wr(REG_CTRL, 32'h0);
      wr(REG_TARGET, 32'h8000);
      wr(REG_VEL, 32'h40);
      wr(REG_CTRL, 32'h1);
      wait_idle(1'b0);
      wr(REG_CTRL, 32'h2);
      for (n = 0; n < 50 && demandSpeed !== 32'h0; n++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      check("ramp length", 32'(opt == 0), 32'(n > 2));
      check("halted", 32'h0, 32'(moving));
      check("reached at rest", 32'h1, 32'(link.statusWord[STAT_REACHED]));
    end
  endtask : t_halt
  // an unsupported method is refused with a warning first, then a good one runs
  task automatic t_homing();
    logic [31:0] rd;
    wr(REG_OPTS, 32'(HOME_METHOD_OK) + 32'h1);
    wr(REG_CTRL, 32'h4);
    wr(REG_CTRL, 32'h5);
    wait_idle(1'b0);
    rdst(rd);
    check("bad method warn", 32'h1, 32'(rd[STAT_WARN]));
    wr(REG_OPTS, 32'(HOME_METHOD_OK));
    wr(REG_CTRL, 32'h5);
    wait_idle(1'b1);
    check("home position", HOME_POSITION, demandPos);
    wr(REG_CTRL, 32'h0);
  endtask : t_homing
  // window 0x9000_0000 is clamped, so a lag above the clamp still errors
  task automatic t_ferr();
    logic [31:0] win[5] = '{32'h0, 32'hffff_ffff, 32'h10, 32'h10, 32'h9000_0000};
    logic [31:0] ofs[5] = '{32'h0, 32'h1000, 32'h100, 32'h0, 32'h0900_0000};
    logic        exp[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [31:0] rd;
    for (int i = 0; i < 5; i++) begin
      posOfs <= ofs[i];
      wr(REG_WINDOW, win[i]);
      repeat (3) @(posedge core_clk);
      rdst(rd);
      check("following error", 32'(exp[i]), 32'(rd[STAT_FERR]));
    end
    posOfs <= 32'h0;
    wr(REG_WINDOW, FERR_WIN_RESET);
  endtask : t_ferr
  // faulty host: strobe low, hold values, raise strobe, then drop it again
  task automatic t_bad(input logic [15:0] cmd, input logic ok, input logic [31:0] expPos);
    @(posedge core_clk);
    link2.cmdWord    <= cmd & 16'hffef;
    // target differs per call, so a wrongly taken set-point shows in the position
    link2.targetPos  <= {16'h0000, cmd};
    link2.profileVel <= 32'h40;
    repeat (3) @(posedge core_clk);
    link2.cmdWord <= cmd;
    repeat (3) @(posedge core_clk);
    check("bad ack", 32'(ok), 32'(link2.statusWord[STAT_ACK]));
    check("bad warn", 32'(!ok), 32'(link2.statusWord[STAT_WARN]));
    link2.cmdWord <= cmd & 16'hffef;
    repeat (20) @(posedge core_clk);
    check("bad position", expPos, demandPos2);
  endtask : t_bad

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    posOfs = 32'h0;
    errors = 0;
    numChecks = 0;
    cycles = 0;
    link2.cmdWord = 16'h0020;
    link2.targetPos = 32'h0;
    link2.profileVel = 32'h0;
    link2.haltOption = 3'h0;
    link2.homingMode = 1'b0;
    link2.homingMethod = 8'h00;
    link2.ferrWindow = FERR_WIN_OFF;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_move();
    t_halt();
    t_homing();
    t_ferr();
    t_bad(16'h0010, 1'b0, 32'h0);
    t_bad(16'h0230, 1'b1, 32'h230);
    t_bad(16'h0070, 1'b0, 32'h230);
    final_report();
  end
endmodule : profile_position_handshake_tb
